// >>> fch_cmd_host.sv
// floppy command interpreter: host bus, command, execution and result phases
`timescale 1ns/10ps
`include "fch_consts.svh"
module fch_cmd_host
   import fch_pkg::*;
#(
   parameter int MS_CYC = `FCH_CLK_MHZ * `FCH_MS_US,
   parameter int POLL_CYC = `FCH_CLK_MHZ * `FCH_POLL_US,
   parameter int POLL_LONG_CYC = `FCH_CLK_MHZ * `FCH_POLL_LONG_US
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic reg_select_line,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   input wire logic dma_ack,
   output logic dma_req,
   input wire logic transfer_end_abort,
   output logic int_out,
   input wire logic drive_ready,
   output logic drive_sel_lo,
   output logic drive_sel_hi,
   output logic head_choice,
   output logic head_load,
   output logic density_select,
   output logic [7:0] inter_sector_gap,
   output logic step_pulse,
   output logic step_dir,
   input wire logic disk_rd_valid,
   input wire logic [7:0] disk_rd_byte,
   output logic disk_wr_req,
   output logic [7:0] disk_wr_byte,
   input wire logic disk_wr_ack
);
   localparam int MSW = $clog2(MS_CYC + 1);
   fch_state_t state_q;
   logic [7:0] cmd_q;
   logic [7:0] prm_q [0:7];
   logic [3:0] prm_idx_q, prm_cnt_q, prm_cnt_new;
   logic [2:0] res_idx_q, res_cnt_q;
   logic [7:0] res0_q, res1_q, st0_q, st1_q, st2_q, res_byte, msr, st3;
   logic [7:0] srt_hut_q, hlt_nd_q, tmr_q, hut_q, tgt_q, gap_q;
   logic [7:0] cyl_q [0:3];
   logic [7:0] c_q, h_q, r_q, data_q;
   logic [13:0] left_q, sect_len;
   logic [MSW-1:0] ms_cnt_q;
   logic ms_tick, tc_m_q, tc_s_q, step_q, dir_q, dens_q, loaded_q, hold_q;
   logic chg_pend_q, seek_pend_q, chg_evt, seek_done, res_done, si_done;
   logic [1:0] chg_drv_q, seek_drv_q, poll_drv, chg_drv, drv, drv_q;
   logic [3:0] rdy_vec;
   logic [4:0] op;
   logic is_rw, is_wr, is_scan, nd, data_acc, wr_acc, rd_acc, host_in, need_host;
   logic disk_evt, overrun, last_sect, xfer_end, polling;

   // command decode and host access qualifiers
   assign op = cmd_q[4:0];
   assign drv = prm_q[0][1:0];
   assign nd = hlt_nd_q[0];
   assign is_wr = (op == `FCH_OP_WRITE);
   assign is_scan = (op == `FCH_OP_SCAN_EQ) || (op == `FCH_OP_SCAN_LE) || (op == `FCH_OP_SCAN_HE);
   assign is_rw = is_wr || is_scan || (op == `FCH_OP_READ);
   assign host_in = is_wr || is_scan;
   assign data_acc = reg_select_line || dma_ack;
   assign wr_acc = bus_wr && data_acc;
   assign rd_acc = bus_rd && data_acc;

   // parameter byte count per opcode
   always_comb begin
      case (bus_wdata[4:0])
         `FCH_OP_SPECIFY: prm_cnt_new = `FCH_PRM_SPECIFY;
         `FCH_OP_SEEK: prm_cnt_new = `FCH_PRM_SEEK;
         `FCH_OP_SENSE_DRV, `FCH_OP_RECAL: prm_cnt_new = `FCH_PRM_ONE;
         `FCH_OP_READ, `FCH_OP_WRITE, `FCH_OP_SCAN_EQ, `FCH_OP_SCAN_LE, `FCH_OP_SCAN_HE: prm_cnt_new = `FCH_PRM_RW;
         default: prm_cnt_new = '0;
      endcase
   end

   // sector length from size code, data length when code is 00
   assign sect_len = (prm_q[4] == 8'h00) ? {6'h00, prm_q[7]} : (`FCH_SECT_BASE << prm_q[4][2:0]);

   // transfer handshake: who owes the next byte
   assign disk_evt = (state_q == FCH_XFER) && (is_wr ? disk_wr_ack : disk_rd_valid);
   assign overrun = disk_evt && (host_in ? !hold_q : hold_q);
   assign last_sect = (r_q == prm_q[5]) && !(cmd_q[7] && h_q[0] == 1'b0);
   assign xfer_end = disk_evt && (overrun || (left_q == 14'h0001 && last_sect));
   assign need_host = (state_q == FCH_XFER) && (host_in ? !hold_q : hold_q);
   assign dma_req = need_host && !nd;
   assign disk_wr_req = (state_q == FCH_XFER) && is_wr && hold_q;
   assign disk_wr_byte = data_q;
   assign res_done = (state_q == FCH_RESULT) && rd_acc && (res_idx_q == res_cnt_q - 3'h1);
   assign si_done = res_done && (op == `FCH_OP_SENSE_INT);
   assign seek_done = (state_q == FCH_STEP) && !tc_s_q && (tmr_q == 8'h00) && (cyl_q[drv] == tgt_q);

   // main status: request, direction, non-DMA, busy, seeking drive
   always_comb begin
      msr = '0;
      msr[`FCH_MSR_RQM] = (state_q == FCH_CMD) || (state_q == FCH_PARAM) || (state_q == FCH_RESULT)
         || (need_host && nd);
      msr[`FCH_MSR_DIO] = (state_q == FCH_RESULT) || (state_q == FCH_HLOAD) || (state_q == FCH_STEP)
         || ((state_q == FCH_XFER) && !host_in);
      msr[5] = (state_q == FCH_XFER) && nd;
      msr[4] = (state_q != FCH_CMD);
      msr[3:0] = 4'((state_q == FCH_STEP)) << drv;
   end

   // drive status byte and result byte mux
   assign st3 = {2'b00, rdy_vec[drv], (cyl_q[drv] == 8'h00), 1'b1, prm_q[0][2], drv};
   always_comb begin
      case (res_idx_q)
         3'h0: res_byte = is_rw ? st0_q : res0_q;
         3'h1: res_byte = is_rw ? st1_q : res1_q;
         3'h2: res_byte = st2_q;
         3'h3: res_byte = c_q;
         3'h4: res_byte = h_q;
         3'h5: res_byte = r_q;
         3'h6: res_byte = prm_q[4];
         default: res_byte = '0;
      endcase
   end

   // registered read data, eight bits wide
   always_ff @(posedge clock) begin
      if (reset) begin
         bus_rdata <= '0;
      end else if (bus_rd) begin
         bus_rdata <= !data_acc ? msr : ((state_q == FCH_RESULT) ? res_byte : data_q);
      end
   end

   // millisecond tick and terminal count synchroniser
   assign ms_tick = (ms_cnt_q == MSW'(MS_CYC - 1));
   always_ff @(posedge clock) begin
      if (reset || ms_tick) begin
         ms_cnt_q <= '0;
      end else begin
         ms_cnt_q <= ms_cnt_q + 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         tc_m_q <= 1'b0;
         tc_s_q <= 1'b0;
      end else begin
         tc_m_q <= transfer_end_abort;
         tc_s_q <= tc_m_q;
      end
   end

   // phase sequencer, seek stepping and result set-up
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= FCH_CMD;
         cmd_q <= '0;
         prm_idx_q <= '0;
         prm_cnt_q <= '0;
         res_idx_q <= '0;
         res_cnt_q <= '0;
         res0_q <= '0;
         res1_q <= '0;
         st0_q <= '0;
         srt_hut_q <= '0;
         hlt_nd_q <= '0;
         tmr_q <= '0;
         tgt_q <= '0;
         step_q <= 1'b0;
         dir_q <= 1'b0;
         dens_q <= 1'b0;
         gap_q <= '0;
         for (int i = 0; i < 4; i++) begin
            cyl_q[i] <= '0;
         end
         for (int i = 0; i < 8; i++) begin
            prm_q[i] <= '0;
         end
      end else begin
         step_q <= 1'b0;
         case (state_q)
            FCH_CMD: if (wr_acc) begin
               cmd_q <= bus_wdata;
               prm_idx_q <= '0;
               prm_cnt_q <= prm_cnt_new;
               state_q <= (prm_cnt_new == 4'h0) ? FCH_START : FCH_PARAM;
            end
            FCH_PARAM: if (wr_acc) begin
               prm_q[prm_idx_q[2:0]] <= bus_wdata;
               prm_idx_q <= prm_idx_q + 4'h1;
               if (prm_idx_q == prm_cnt_q - 4'h1) begin
                  state_q <= FCH_START;
               end
            end
            FCH_START: begin
               res_idx_q <= '0;
               if (op == `FCH_OP_SPECIFY) begin
                  srt_hut_q <= prm_q[0];
                  hlt_nd_q <= prm_q[1];
                  state_q <= FCH_CMD;
               end else if (op == `FCH_OP_SENSE_DRV) begin
                  res0_q <= st3;
                  res_cnt_q <= `FCH_RES_ONE;
                  state_q <= FCH_RESULT;
               end else if (op == `FCH_OP_SEEK || op == `FCH_OP_RECAL) begin
                  tgt_q <= (op == `FCH_OP_RECAL) ? 8'h00 : ((prm_q[1] > `FCH_MAX_CYL) ? `FCH_MAX_CYL : prm_q[1]);
                  tmr_q <= '0;
                  state_q <= FCH_STEP;
               end else if (op == `FCH_OP_SENSE_INT) begin
                  res_cnt_q <= (chg_pend_q || seek_pend_q) ? `FCH_RES_TWO : `FCH_RES_ONE;
                  if (chg_pend_q) begin
                     res0_q <= {`FCH_IC_RDY, 2'b00, !rdy_vec[chg_drv_q], 1'b0, chg_drv_q};
                     res1_q <= cyl_q[chg_drv_q];
                  end else if (seek_pend_q) begin
                     res0_q <= {`FCH_IC_NORMAL, 1'b1, 1'b0, !rdy_vec[seek_drv_q], 1'b0, seek_drv_q};
                     res1_q <= cyl_q[seek_drv_q];
                  end else begin
                     res0_q <= `FCH_ST0_INVALID;
                  end
                  state_q <= FCH_RESULT;
               end else if (is_rw) begin
                  dens_q <= cmd_q[6];
                  gap_q <= prm_q[6];
                  st0_q <= {`FCH_IC_NORMAL, 3'b000, prm_q[0][2], drv};
                  res_cnt_q <= `FCH_RES_RW;
                  tmr_q <= {hlt_nd_q[7:1], 1'b0};
                  state_q <= loaded_q ? FCH_XFER : FCH_HLOAD;
               end else begin
                  res0_q <= `FCH_ST0_INVALID;
                  res_cnt_q <= `FCH_RES_ONE;
                  state_q <= FCH_RESULT;
               end
            end
            FCH_HLOAD: if (tc_s_q) begin
               st0_q[7:6] <= `FCH_IC_ABN;
               state_q <= FCH_RESULT;
            end else if (tmr_q == 8'h00) begin
               state_q <= FCH_XFER;
            end else if (ms_tick) begin
               tmr_q <= tmr_q - 8'h01;
            end
            FCH_XFER: if (tc_s_q || xfer_end) begin
               st0_q[7:6] <= overrun ? `FCH_IC_ABN : `FCH_IC_NORMAL;
               state_q <= FCH_RESULT;
            end
            FCH_STEP: if (tc_s_q || seek_done) begin
               state_q <= FCH_CMD;
            end else if (tmr_q != 8'h00) begin
               tmr_q <= ms_tick ? tmr_q - 8'h01 : tmr_q;
            end else begin
               step_q <= 1'b1;
               dir_q <= (tgt_q > cyl_q[drv]);
               cyl_q[drv] <= (tgt_q > cyl_q[drv]) ? cyl_q[drv] + 8'h01 : cyl_q[drv] - 8'h01;
               tmr_q <= `FCH_SRT_BASE - {4'h0, srt_hut_q[7:4]};
            end
            FCH_RESULT: if (rd_acc) begin
               res_idx_q <= res_idx_q + 3'h1;
               if (res_done) begin
                  state_q <= FCH_CMD;
               end
            end
            default: state_q <= FCH_CMD;
         endcase
      end
   end

   // sector data path: byte hand-off, sector and head advance
   always_ff @(posedge clock) begin
      if (reset) begin
         hold_q <= 1'b0;
         data_q <= '0;
         left_q <= '0;
         c_q <= '0;
         h_q <= '0;
         r_q <= '0;
         st1_q <= '0;
         st2_q <= '0;
      end else if (state_q == FCH_START) begin
         hold_q <= 1'b0;
         c_q <= prm_q[1];
         h_q <= {7'h00, prm_q[0][2]};
         r_q <= prm_q[3];
         left_q <= sect_len;
         st1_q <= '0;
         st2_q <= '0;
      end else if (state_q == FCH_XFER) begin
         if (rd_acc && !host_in) begin
            hold_q <= 1'b0;
         end else if (wr_acc && host_in && !hold_q) begin
            data_q <= bus_wdata;
            hold_q <= 1'b1;
         end
         if (overrun) begin
            st1_q[`FCH_ST1_OR] <= 1'b1;
         end else if (disk_evt) begin
            hold_q <= !host_in;
            if (!is_wr) begin
               data_q <= is_scan ? data_q : disk_rd_byte;
            end
            if (is_scan && data_q != disk_rd_byte) begin
               st2_q[`FCH_ST2_SNS] <= 1'b1;
            end
            left_q <= left_q - 14'h0001;
            if (left_q == 14'h0001) begin
               left_q <= sect_len;
               if (r_q != prm_q[5]) begin
                  r_q <= r_q + (is_scan ? prm_q[7] : 8'h01);
               end else if (cmd_q[7] && h_q[0] == 1'b0) begin
                  h_q <= 8'h01;
                  r_q <= 8'h01;
               end else begin
                  c_q <= c_q + 8'h01;
                  r_q <= 8'h01;
               end
            end
         end
      end
   end

   // pending interrupts, set wins over clear
   always_ff @(posedge clock) begin
      if (reset) begin
         chg_pend_q <= 1'b0;
         chg_drv_q <= '0;
         seek_pend_q <= 1'b0;
         seek_drv_q <= '0;
      end else begin
         chg_pend_q <= chg_evt || (chg_pend_q && !si_done);
         chg_drv_q <= chg_evt ? chg_drv : chg_drv_q;
         seek_pend_q <= seek_done || (seek_pend_q && !(si_done && !chg_pend_q));
         seek_drv_q <= seek_done ? drv : seek_drv_q;
      end
   end
   assign int_out = chg_pend_q || seek_pend_q || ((state_q == FCH_RESULT) && is_rw);

   // head load state and unload timer
   always_ff @(posedge clock) begin
      if (reset) begin
         loaded_q <= 1'b0;
         hut_q <= '0;
      end else if (state_q == FCH_HLOAD && tmr_q == 8'h00 && !tc_s_q) begin
         loaded_q <= 1'b1;
      end else if (state_q == FCH_XFER && (tc_s_q || xfer_end)) begin
         hut_q <= {srt_hut_q[3:0], 4'h0};
      end else if (state_q == FCH_CMD && loaded_q && ms_tick) begin
         hut_q <= hut_q - 8'h01;
         loaded_q <= (hut_q > 8'h01);
      end
   end

   // drive select: poll between commands and between steps
   assign polling = (state_q == FCH_CMD) || (state_q == FCH_STEP && tmr_q != 8'h00);
   always_ff @(posedge clock) begin
      if (reset) begin
         drv_q <= '0;
      end else begin
         drv_q <= polling ? poll_drv : drv;
      end
   end
   assign drive_sel_lo = drv_q[0];
   assign drive_sel_hi = drv_q[1];
   assign head_choice = h_q[0];
   assign head_load = loaded_q;
   assign density_select = dens_q;
   assign inter_sector_gap = gap_q;
   assign step_pulse = step_q;
   assign step_dir = dir_q;

   fch_ready_poll #(
      .POLL_CYC(POLL_CYC),
      .POLL_LONG_CYC(POLL_LONG_CYC)
   ) u_poll (
      .clock(clock),
      .reset(reset),
      .poll_en(polling),
      .drive_ready(drive_ready),
      .poll_drv(poll_drv),
      .rdy_vec(rdy_vec),
      .chg_evt(chg_evt),
      .chg_drv(chg_drv)
   );

   // checks on the phase handshake and timing
   msr_sel_a: assert property (@(posedge clock) disable iff (reset)
      (bus_rd && !reg_select_line && !dma_ack) |=> (bus_rdata == $past(msr))) else $error("status read wrong");
   exec_flags_a: assert property (@(posedge clock) disable iff (reset)
      (state_q == FCH_HLOAD || state_q == FCH_STEP) |-> (msr[6] && !msr[7])) else $error("exec flags wrong");
   cyl_range_a: assert property (@(posedge clock) disable iff (reset)
      cyl_q[drv] <= `FCH_MAX_CYL) else $error("cylinder out of range");
   result_end_a: assert property (@(posedge clock) disable iff (reset)
      res_done |=> (state_q == FCH_CMD) && msr[7] && !msr[6]) else $error("command not ended");
   tc_abort_a: assert property (@(posedge clock) disable iff (reset)
      (tc_s_q && (state_q == FCH_HLOAD || state_q == FCH_XFER)) |=> (state_q == FCH_RESULT)) else $error("abort missed");
   int_hold_a: assert property (@(posedge clock) disable iff (reset)
      (chg_pend_q && !si_done) |=> (chg_pend_q && int_out)) else $error("ready interrupt dropped");
   density_a: assert property (@(posedge clock) disable iff (reset)
      (state_q == FCH_XFER) |-> (density_select == cmd_q[6])) else $error("density mismatch");
   hload_time_a: assert property (@(posedge clock) disable iff (reset)
      (state_q == FCH_START && is_rw && !loaded_q) |=> (state_q == FCH_HLOAD) && (tmr_q == {hlt_nd_q[7:1], 1'b0}))
      else $error("head load delay wrong");
   nodma_a: assert property (@(posedge clock) disable iff (reset)
      (need_host && nd) |-> (!dma_req && msr[7])) else $error("non-DMA request wrong");
   rw_done_c: cover property (@(posedge clock) disable iff (reset) res_done && is_rw);
   ready_int_c: cover property (@(posedge clock) disable iff (reset) si_done && chg_pend_q);
   tc_abort_c: cover property (@(posedge clock) disable iff (reset) tc_s_q && state_q == FCH_XFER);
   seek_done_c: cover property (@(posedge clock) disable iff (reset) seek_done);
endmodule

// >>> fch_consts.svh
// named constants for the floppy command interpreter
`ifndef FCH_CONSTS_SVH
`define FCH_CONSTS_SVH
`define FCH_CLK_MHZ 125
`define FCH_MS_US 1000
`define FCH_POLL_US 220
`define FCH_POLL_LONG_US 440
`define FCH_MAX_CYL 8'h4C
`define FCH_OP_SPECIFY 5'h03
`define FCH_OP_SENSE_DRV 5'h04
`define FCH_OP_WRITE 5'h05
`define FCH_OP_READ 5'h06
`define FCH_OP_RECAL 5'h07
`define FCH_OP_SENSE_INT 5'h08
`define FCH_OP_SEEK 5'h0F
`define FCH_OP_SCAN_EQ 5'h11
`define FCH_OP_SCAN_LE 5'h19
`define FCH_OP_SCAN_HE 5'h1D
`define FCH_PRM_RW 4'h8
`define FCH_PRM_SPECIFY 4'h2
`define FCH_PRM_SEEK 4'h2
`define FCH_PRM_ONE 4'h1
`define FCH_RES_RW 3'h7
`define FCH_RES_TWO 3'h2
`define FCH_RES_ONE 3'h1
`define FCH_MSR_RQM 7
`define FCH_MSR_DIO 6
`define FCH_ST0_INVALID 8'h80
`define FCH_IC_NORMAL 2'h0
`define FCH_IC_ABN 2'h1
`define FCH_IC_RDY 2'h3
`define FCH_ST1_OR 4
`define FCH_ST2_SNS 2
`define FCH_SRT_BASE 8'h10
`define FCH_SECT_BASE 14'h0080
`define FCH_DRV_LAST 2'h3
`endif

// >>> fch_pkg.sv
// types for the floppy command interpreter
package fch_pkg;
   typedef enum logic [2:0] {
      FCH_CMD = 3'b000,
      FCH_PARAM = 3'b001,
      FCH_START = 3'b010,
      FCH_HLOAD = 3'b011,
      FCH_XFER = 3'b100,
      FCH_STEP = 3'b101,
      FCH_RESULT = 3'b110
   } fch_state_t;
endpackage

// >>> fch_ready_poll.sv
// drive ready poller: cycles drive codes and flags ready changes
`timescale 1ns/10ps
`include "fch_consts.svh"
module fch_ready_poll
   import fch_pkg::*;
#(
   parameter int POLL_CYC = `FCH_CLK_MHZ * `FCH_POLL_US,
   parameter int POLL_LONG_CYC = `FCH_CLK_MHZ * `FCH_POLL_LONG_US
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic poll_en,
   input wire logic drive_ready,
   output logic [1:0] poll_drv,
   output logic [3:0] rdy_vec,
   output logic chg_evt,
   output logic [1:0] chg_drv
);
   localparam int PW = $clog2(POLL_LONG_CYC + 1);
   logic rdy_m_q;
   logic rdy_s_q;
   logic [PW-1:0] dwell_q;
   logic [PW-1:0] lim;
   logic dwell_done;
   logic [3:0] seen_q;

   // two-stage synchroniser for the ready pin
   always_ff @(posedge clock) begin
      if (reset) begin
         rdy_m_q <= 1'b0;
         rdy_s_q <= 1'b0;
      end else begin
         rdy_m_q <= drive_ready;
         rdy_s_q <= rdy_m_q;
      end
   end

   // longer dwell on the last drive code
   assign lim = (poll_drv == `FCH_DRV_LAST) ? PW'(POLL_LONG_CYC - 1) : PW'(POLL_CYC - 1);
   assign dwell_done = poll_en && (dwell_q == lim);

   // dwell restarts after a pause so the command drive's stale level is never sampled
   always_ff @(posedge clock) begin
      if (reset || dwell_done || !poll_en) begin
         dwell_q <= '0;
      end else if (poll_en) begin
         dwell_q <= dwell_q + 1'b1;
      end
   end

   // sample ready at dwell end, step to next drive
   always_ff @(posedge clock) begin
      if (reset) begin
         poll_drv <= '0;
         rdy_vec <= '0;
         seen_q <= '0;
         chg_evt <= 1'b0;
         chg_drv <= '0;
      end else begin
         chg_evt <= 1'b0;
         if (dwell_done) begin
            rdy_vec[poll_drv] <= rdy_s_q;
            seen_q[poll_drv] <= 1'b1;
            chg_evt <= seen_q[poll_drv] && (rdy_vec[poll_drv] != rdy_s_q);
            chg_drv <= poll_drv;
            poll_drv <= poll_drv + 2'h1;
         end
      end
   end

   poll_dwell_a: assert property (@(posedge clock) disable iff (reset)
      (poll_drv != $past(poll_drv)) |-> $past(dwell_done)) else $error("drive code moved early");
endmodule

// >>> fch_drive_model.sv
// drive side model: per-drive ready lines and disk byte source
`timescale 1ns/10ps
module fch_drive_model (
   input wire logic clock,
   input wire logic drive_sel_lo,
   input wire logic drive_sel_hi,
   input wire logic [3:0] ready_mask,
   input wire logic send,
   input wire logic [7:0] send_byte,
   input wire logic disk_wr_req,
   output logic drive_ready,
   output logic disk_wr_ack,
   output logic disk_rd_valid,
   output logic [7:0] disk_rd_byte
);
   // ready line of whichever drive the code points at
   assign drive_ready = ready_mask[{drive_sel_hi, drive_sel_lo}];
   // one byte pulse on request, junk that changes otherwise
   initial begin
      disk_rd_valid = 0;
      disk_rd_byte = 8'h00;
      disk_wr_ack = 0;
   end
   always @(posedge clock) begin
      disk_rd_valid <= send;
      disk_rd_byte <= send ? send_byte : ~disk_rd_byte;
      disk_wr_ack <= disk_wr_req & ~disk_wr_ack;
   end
endmodule

// >>> tb.sv
// self-checking bench for the floppy command interpreter
`timescale 1ns/10ps
module tb;
   localparam int PC = 8;
   localparam int PLC = 16;
   logic clock, reset, sel, rd, wr, tc, snd, int_out, dsl, dsh;
   logic hc, hl, dens, sp, sd, rdv, wrq, wack, dreq, rdy;
   logic [7:0] wdata, rdata, b, gap, rdb, wrb;
   logic [3:0] rmask;
   logic [7:0] res [7];
   logic [7:0] rcmd [9] = '{8'h46, 8'h00, 8'h4C, 8'h00, 8'h01, 8'h01, 8'h01, 8'h1B, 8'hFF};
   int failures, compares, steps, n;
   fch_cmd_host #(.MS_CYC(20), .POLL_CYC(PC), .POLL_LONG_CYC(PLC)) dut_u (.clock(clock), .reset(reset),
      .reg_select_line(sel), .bus_rd(rd), .bus_wr(wr), .bus_wdata(wdata), .bus_rdata(rdata),
      .dma_ack(1'b0), .dma_req(dreq), .transfer_end_abort(tc), .int_out(int_out), .drive_ready(rdy),
      .drive_sel_lo(dsl), .drive_sel_hi(dsh), .head_choice(hc), .head_load(hl), .density_select(dens),
      .inter_sector_gap(gap), .step_pulse(sp), .step_dir(sd), .disk_rd_valid(rdv), .disk_rd_byte(rdb),
      .disk_wr_req(wrq), .disk_wr_byte(wrb), .disk_wr_ack(wack));
   fch_drive_model drv_u (.clock(clock), .drive_sel_lo(dsl), .drive_sel_hi(dsh), .ready_mask(rmask),
      .send(snd), .send_byte(8'hA5), .disk_wr_req(wrq), .drive_ready(rdy), .disk_wr_ack(wack),
      .disk_rd_valid(rdv), .disk_rd_byte(rdb));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      if (failures == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // one-cycle strobes, launched just after an edge
   task automatic wr_b(input logic s, input logic [7:0] d);
      @(posedge clock);
      #1;
      sel = s;
      wdata = d;
      wr = 1;
      @(posedge clock);
      #1;
      wr = 0;
   endtask
   task automatic rd_b(input logic s, output logic [7:0] d);
      @(posedge clock);
      #1;
      sel = s;
      rd = 1;
      @(posedge clock);
      #1;
      rd = 0;
      d = rdata;
   endtask
   // read status until the top two bits match, bounded
   task automatic poll(input logic [1:0] want);
      for (int i = 0; i < 3000; i++) begin
         rd_b(1'b0, b);
         if (b[7:6] === want) return;
      end
      failures++;
      summarize();
   endtask
   task automatic cmd(input logic [7:0] d);
      poll(2'b10);
      wr_b(1'b1, d);
   endtask
   // wait for interrupt (0) or head load (1), bounded
   task automatic wt(input logic k);
      for (int i = 0; i < 3000; i++) begin
         @(posedge clock);
         #1;
         if ((k ? hl : int_out) === 1'b1) return;
      end
      failures++;
      summarize();
   endtask
   // length of the next run of a drive code
   task automatic run(input logic [1:0] c);
      n = 0;
      for (int i = 0; i < 200 && {dsh, dsl} !== c; i++) begin
         @(posedge clock);
         #1;
      end
      while ({dsh, dsl} === c && n < 200) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n == 0 || n >= 200) begin
         failures++;
         summarize();
      end
   endtask
   initial begin
      clock = 0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) if (sp === 1'b1) steps++;
   initial begin
      {reset, sel, rd, wr, tc, snd} = 6'h20;
      {wdata, rmask, failures, compares, steps} = '0;
      rmask = 4'hF;
      repeat (20) @(posedge clock);
      #1;
      reset = 0;
      rd_b(0, b);
      chk("status idle", b, 8'h80);
      wr_b(0, 8'h03);
      rd_b(0, b);
      chk("status after low write", b, 8'h80);
      run(0);
      run(1);
      chk("dwell 01", n[7:0], 8'(PC));
      run(3);
      run(3);
      chk("dwell 11", n[7:0], 8'(PLC));
      // specify: 1 ms step, 16 ms unload, 4 ms load, no DMA
      cmd(8'h03);
      cmd(8'hF1);
      cmd(8'h05);
      cmd(8'h00);
      poll(2'b11);
      rd_b(1, b);
      chk("invalid result", b, 8'h80);
      rd_b(0, b);
      chk("status after result", b, 8'h80);
      cmd(8'h04);
      cmd(8'h05);
      poll(2'b11);
      rd_b(1, b);
      chk("drive status", b, 8'h3D);
      // seek past the last cylinder
      cmd(8'h0F);
      cmd(8'h00);
      cmd(8'h64);
      wt(0);
      chk("step count", steps[7:0], 8'h4C);
      chk("step dir", {7'h00, sd}, 8'h01);
      cmd(8'h08);
      poll(2'b11);
      rd_b(1, b);
      chk("seek status", b, 8'h20);
      rd_b(1, b);
      chk("cylinder", b, 8'h4C);
      // drive 2 drops off line
      rmask = 4'hB;
      wt(0);
      cmd(8'h08);
      poll(2'b11);
      rd_b(1, b);
      chk("ready change", b, 8'hCA);
      chk("int held", {7'h00, int_out}, 8'h01);
      rd_b(1, b);
      chk("int cleared", {7'h00, int_out}, 8'h00);
      // read: head load, one byte, then terminal count
      for (int i = 0; i < 9; i++) cmd(rcmd[i]);
      rd_b(0, b);
      chk("load status", b & 8'hC0, 8'h40);
      wt(1);
      chk("density", {7'h00, dens}, 8'h01);
      chk("gap", gap, 8'h1B);
      chk("head", {7'h00, hc}, 8'h00);
      snd = 1;
      @(posedge clock);
      #1;
      snd = 0;
      poll(2'b11);
      chk("xfer status", b, 8'hF0);
      chk("no dma request", {7'h00, dreq}, 8'h00);
      rd_b(1, b);
      chk("read byte", b, 8'hA5);
      tc = 1;
      repeat (4) @(posedge clock);
      #1;
      tc = 0;
      poll(2'b11);
      for (int i = 0; i < 7; i++) rd_b(1, res[i]);
      chk("abort st0", res[0] & 8'hC0, 8'h00);
      chk("abort cyl", res[3], 8'h4C);
      rd_b(0, b);
      chk("status end", b, 8'h80);
      summarize();
   end
endmodule
